// [core/pca_pkg.sv]
// Shared constants, register map and carrier types of the counter array.
package pca_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_MODULES = 5;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int WDOG_MODULE = 4;

    // ----------------------------------------------------------------
    // Register indexes; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h0D8;
    localparam logic [IDX_W-1:0] IDX_WDOG_CTRL = 10'h0D9;
    localparam logic [IDX_W-1:0] IDX_MODE_BASE = 10'h0DA;
    localparam logic [IDX_W-1:0] IDX_COUNT_LOW = 10'h0E9;
    localparam logic [IDX_W-1:0] IDX_CMP_LOW_BASE = 10'h0EA;
    localparam logic [IDX_W-1:0] IDX_COUNT_HIGH = 10'h0F9;
    localparam logic [IDX_W-1:0] IDX_CMP_HIGH_BASE = 10'h0FA;

    // ----------------------------------------------------------------
    // Field positions and values
    // ----------------------------------------------------------------
    localparam int FLAG_RUN_BIT = 6;
    localparam int WDOG_EN_BIT = 0;
    localparam int WDOG_SEEN_BIT = 1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] COUNT_LOW_MAX = 8'hFF;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic reserved;
        logic compare_enable;
        logic positive_edge_capture_enable;
        logic negative_edge_capture_enable;
        logic equal_flag_enable;
        logic flip_output_enable;
        logic pulse_width_enable;
        logic module_irq_enable;
    } mode_s;

    localparam mode_s MODE_RESET = '0;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_s;

endpackage : pca_pkg

// [core/pca_module_unit.sv]
// One compare/capture module: edge capture, match, toggle output and PWM.
`timescale 1ns/1ps
module pca_module_unit (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire pca_pkg::mode_s mode,
    input wire logic [15:0] count,
    input wire logic moved,
    input wire logic wrap,
    input wire logic [7:0] cmp_lo,
    input wire logic [7:0] cmp_hi,
    input wire logic pin_in,
    output logic capture,
    output logic match,
    output logic pin_out,
    output logic pin_oe
);
    import pca_pkg::*;

    typedef struct packed {
        logic primed;
        logic pin_prev;
        logic [7:0] duty;
        logic hso_level;
        logic pin_out;
        logic pin_oe;
    } unit_state_s;

    unit_state_s s_q;
    unit_state_s s_d;
    logic pwm_on;
    logic hso_on;

    always_comb begin
        s_d = s_q;
        s_d.pin_prev = pin_in;
        s_d.primed = 1'b1;
        capture = s_q.primed &&
            ((mode.positive_edge_capture_enable && pin_in && !s_q.pin_prev) ||
             (mode.negative_edge_capture_enable && !pin_in && s_q.pin_prev));
        match = moved && mode.compare_enable && mode.equal_flag_enable &&
            (count == {cmp_hi, cmp_lo});
        hso_on = mode.flip_output_enable && mode.equal_flag_enable && mode.compare_enable;
        if (match && mode.flip_output_enable) begin
            s_d.hso_level = !s_q.hso_level;
        end
        pwm_on = mode.pulse_width_enable && mode.compare_enable;
        if (wrap) begin
            s_d.duty = cmp_hi;
        end
        if (pwm_on) begin
            s_d.pin_out = (count[7:0] >= s_q.duty);
        end else begin
            s_d.pin_out = s_d.hso_level;
        end
        s_d.pin_oe = pwm_on || hso_on;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{primed: 1'b0, pin_prev: 1'b0, duty: BYTE_ZERO, hso_level: PIN_IDLE,
                     pin_out: PIN_IDLE, pin_oe: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_out = s_q.pin_out;
    assign pin_oe = s_q.pin_oe;

endmodule : pca_module_unit

// [core/pca_compare_capture_watchdog.sv]
// Five-module counter array with capture, compare, toggle, PWM and watchdog.
//
// Behaviour
// - Capture runs when either or both edge enables are set; pin watched.
// - Valid pin edge copies counter high and low into the compare bytes.
// - Event sets module flag; interrupt only while flag and enable both set.
// - With compare and match enables, equality of counter and value flags.
// - Writing the compare low byte clears compare enable.
// - Writing the compare high byte sets compare enable.
// - Compare enable also directly readable and writable in the mode register.
// - Toggle mode inverts the pin on every match.
// - Toggle mode needs toggle, match and compare enables all set.
// - All PWM outputs share the counter frequency; duty is per module.
// - PWM pin low while counter low byte below duty, otherwise high.
// - Duty reloads from compare high byte when low byte wraps to zero.
// - PWM needs pulse width enable and compare enable.
// - Only module 4 does watchdog; otherwise it works in any mode.
// - Watchdog match of 16-bit value and counter raises internal reset.
// - Watchdog reset stays internal; no reset pin is driven.
// - Clearing watchdog enable before a match suppresses the reset.
// - Counter low byte is a read/write register, reset zero.
// - Counter high byte is a read/write register, reset zero.
// - Mode register bits 6..0 hold the module enables; bit 7 reserved.
// - Compare value bytes reset to zero.
`timescale 1ns/1ps
module pca_compare_capture_watchdog (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire pca_pkg::axil_req_s axil_req,
    output pca_pkg::axil_rsp_s axil_rsp,
    input wire logic [pca_pkg::NUM_MODULES-1:0] module_io_pin_in,
    output logic [pca_pkg::NUM_MODULES-1:0] module_io_pin_out,
    output logic [pca_pkg::NUM_MODULES-1:0] module_io_pin_oe,
    output logic module_irq,
    output logic watchdog_reset_req
);
    import pca_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [7:0] w_byte;
        logic w_en;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [15:0] count;
        logic moved;
        logic wrap;
        logic run;
        logic [NUM_MODULES-1:0] flags;
        logic wdog_en;
        logic wdog_seen;
        logic wdog_reset;
        logic irq;
        logic [NUM_MODULES-1:0][7:0] cmp_lo;
        logic [NUM_MODULES-1:0][7:0] cmp_hi;
        logic [NUM_MODULES-1:0][7:0] mode;
    } top_state_s;

    top_state_s s_q;
    top_state_s s_d;

    logic [NUM_MODULES-1:0] capture;
    logic [NUM_MODULES-1:0] match;
    logic [NUM_MODULES-1:0] unit_pin_out;
    logic [NUM_MODULES-1:0] unit_pin_oe;
    logic [NUM_MODULES-1:0] irq_en;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic bank_hit(input logic [IDX_W-1:0] idx,
                                      input logic [IDX_W-1:0] base);
        bank_hit = (idx >= base) && (idx < base + IDX_W'(NUM_MODULES));
    endfunction : bank_hit

    function automatic logic [2:0] bank_sel(input logic [IDX_W-1:0] idx,
                                            input logic [IDX_W-1:0] base);
        logic [IDX_W-1:0] diff;
        diff = idx - base;
        bank_sel = diff[2:0];
    endfunction : bank_sel

    function automatic logic [IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] addr);
        addr_idx = addr[ADDR_W-1:2];
    endfunction : addr_idx

    // Compare enable is one field of the stored mode byte.
    function automatic logic [7:0] set_cmp_en(input logic [7:0] mode_byte,
                                              input logic value);
        mode_s m;
        m = mode_s'(mode_byte);
        m.compare_enable = value;
        set_cmp_en = m;
    endfunction : set_cmp_en

    // Interrupt enable field of a stored mode byte.
    function automatic logic irq_bit(input logic [7:0] mode_byte);
        mode_s m;
        m = mode_s'(mode_byte);
        irq_bit = m.module_irq_enable;
    endfunction : irq_bit

    // ----------------------------------------------------------------
    // Module units
    // ----------------------------------------------------------------
    // One counter feeds every unit, so all PWM outputs share a frequency
    // while each unit keeps its own duty byte.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MODULES; gi++) begin : g_unit
            pca_module_unit u_unit (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .mode(mode_s'(s_q.mode[gi])),
                .count(s_q.count),
                .moved(s_q.moved),
                .wrap(s_q.wrap),
                .cmp_lo(s_q.cmp_lo[gi]),
                .cmp_hi(s_q.cmp_hi[gi]),
                .pin_in(module_io_pin_in[gi]),
                .capture(capture[gi]),
                .match(match[gi]),
                .pin_out(unit_pin_out[gi]),
                .pin_oe(unit_pin_oe[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [IDX_W-1:0] ridx;
        logic [IDX_W-1:0] widx;
        logic [2:0] sel;
        logic hit;
        mode_s wmode;
        ridx = addr_idx(axil_req.araddr);
        widx = addr_idx(s_q.aw_addr);
        sel = 3'h0;
        hit = 1'b0;
        wmode = MODE_RESET;
        irq_en = '0;
        s_d = s_q;
        s_d.moved = 1'b0;
        s_d.wrap = 1'b0;
        s_d.wdog_reset = 1'b0;

        if (s_q.run) begin
            s_d.count = s_q.count + COUNT_STEP;
            s_d.moved = 1'b1;
            s_d.wrap = (s_q.count[7:0] == COUNT_LOW_MAX);
        end

        // Read channel: one outstanding read, data sampled at acceptance.
        if (s_q.rvalid && axil_req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_q.arready && axil_req.arvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = BYTE_ZERO;
            if (ridx == IDX_FLAGS) begin
                s_d.rdata[FLAG_RUN_BIT] = s_q.run;
                s_d.rdata[NUM_MODULES-1:0] = s_q.flags;
            end else if (ridx == IDX_WDOG_CTRL) begin
                s_d.rdata[WDOG_EN_BIT] = s_q.wdog_en;
                s_d.rdata[WDOG_SEEN_BIT] = s_q.wdog_seen;
            end else if (ridx == IDX_COUNT_LOW) begin
                s_d.rdata = s_q.count[7:0];
            end else if (ridx == IDX_COUNT_HIGH) begin
                s_d.rdata = s_q.count[15:8];
            end else if (bank_hit(ridx, IDX_MODE_BASE)) begin
                s_d.rdata = {1'b0, s_q.mode[bank_sel(ridx, IDX_MODE_BASE)][6:0]};
            end else if (bank_hit(ridx, IDX_CMP_LOW_BASE)) begin
                s_d.rdata = s_q.cmp_lo[bank_sel(ridx, IDX_CMP_LOW_BASE)];
            end else if (bank_hit(ridx, IDX_CMP_HIGH_BASE)) begin
                s_d.rdata = s_q.cmp_hi[bank_sel(ridx, IDX_CMP_HIGH_BASE)];
            end else begin
                s_d.rresp = RESP_SLVERR;
            end
        end

        // Write channels are taken independently and joined here.
        if (s_q.bvalid && axil_req.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.awready && axil_req.awvalid) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = axil_req.awaddr;
        end
        if (s_q.wready && axil_req.wvalid) begin
            s_d.w_full = 1'b1;
            s_d.w_byte = axil_req.wdata[7:0];
            s_d.w_en = axil_req.wstrb[0];
        end
        if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
            s_d.aw_full = 1'b0;
            s_d.w_full = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            hit = 1'b1;
            wmode = mode_s'(s_q.w_byte);
            if (widx == IDX_FLAGS) begin
                // Zero clears a flag; a hardware set this cycle still wins below.
                if (s_q.w_en) begin
                    s_d.run = s_q.w_byte[FLAG_RUN_BIT];
                    s_d.flags = s_q.flags & s_q.w_byte[NUM_MODULES-1:0];
                end
            end else if (widx == IDX_WDOG_CTRL) begin
                // The fired bit only clears from software; the watchdog sets it.
                if (s_q.w_en) begin
                    s_d.wdog_en = s_q.w_byte[WDOG_EN_BIT];
                    s_d.wdog_seen = s_q.wdog_seen && s_q.w_byte[WDOG_SEEN_BIT];
                end
            end else if (widx == IDX_COUNT_LOW) begin
                if (s_q.w_en) begin
                    s_d.count[7:0] = s_q.w_byte;
                    s_d.moved = 1'b1;
                end
            end else if (widx == IDX_COUNT_HIGH) begin
                if (s_q.w_en) begin
                    s_d.count[15:8] = s_q.w_byte;
                    s_d.moved = 1'b1;
                end
            end else if (bank_hit(widx, IDX_MODE_BASE)) begin
                sel = bank_sel(widx, IDX_MODE_BASE);
                if (s_q.w_en) begin
                    wmode.reserved = 1'b0;
                    s_d.mode[sel] = wmode;
                end
            end else if (bank_hit(widx, IDX_CMP_LOW_BASE)) begin
                sel = bank_sel(widx, IDX_CMP_LOW_BASE);
                if (s_q.w_en) begin
                    s_d.cmp_lo[sel] = s_q.w_byte;
                    s_d.mode[sel] = set_cmp_en(s_q.mode[sel], 1'b0);
                end
            end else if (bank_hit(widx, IDX_CMP_HIGH_BASE)) begin
                sel = bank_sel(widx, IDX_CMP_HIGH_BASE);
                if (s_q.w_en) begin
                    s_d.cmp_hi[sel] = s_q.w_byte;
                    s_d.mode[sel] = set_cmp_en(s_q.mode[sel], 1'b1);
                end
            end else begin
                hit = 1'b0;
            end
            if (!hit) begin
                s_d.bresp = RESP_SLVERR;
            end
        end

        // Capture lands after the bus write so a pin edge is never lost
        // to a simultaneous software write of the same bytes.
        for (int i = 0; i < NUM_MODULES; i++) begin
            if (capture[i]) begin
                s_d.cmp_lo[i] = s_q.count[7:0];
                s_d.cmp_hi[i] = s_q.count[15:8];
            end
            irq_en[i] = irq_bit(s_d.mode[i]);
        end

        s_d.flags = s_d.flags | capture | match;

        if (match[WDOG_MODULE] && s_q.wdog_en) begin
            s_d.wdog_reset = 1'b1;
            s_d.wdog_seen = 1'b1;
        end

        s_d.irq = |(s_d.flags & irq_en);

        // A channel stays closed while it holds a word or an answer waits.
        s_d.awready = !s_d.aw_full && !s_d.bvalid;
        s_d.wready = !s_d.w_full && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.cmp_lo <= '0;
            s_q.cmp_hi <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // The reset request is a separate internal line; nothing here can
    // pull the device reset pin.
    // reset kept internal
    assign watchdog_reset_req = s_q.wdog_reset;
    assign module_irq = s_q.irq;
    assign module_io_pin_out = unit_pin_out;
    assign module_io_pin_oe = unit_pin_oe;

    assign axil_rsp.awready = s_q.awready;
    assign axil_rsp.wready = s_q.wready;
    assign axil_rsp.bvalid = s_q.bvalid;
    assign axil_rsp.bresp = s_q.bresp;
    assign axil_rsp.arready = s_q.arready;
    assign axil_rsp.rvalid = s_q.rvalid;
    assign axil_rsp.rdata = {24'h000000, s_q.rdata};
    assign axil_rsp.rresp = s_q.rresp;

endmodule : pca_compare_capture_watchdog

// [verif/pca_monitor.sv]
// Port checker of the counter array, bound to its top module.
`timescale 1ns/1ps
module pca_monitor (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire pca_pkg::axil_req_s axil_req,
    input wire pca_pkg::axil_rsp_s axil_rsp,
    input wire logic [pca_pkg::NUM_MODULES-1:0] module_io_pin_in,
    input wire logic [pca_pkg::NUM_MODULES-1:0] module_io_pin_out,
    input wire logic [pca_pkg::NUM_MODULES-1:0] module_io_pin_oe,
    input wire logic module_irq,
    input wire logic watchdog_reset_req
);
    import pca_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    AST_READ_ANSWER: assert property (axil_req.arvalid && axil_rsp.arready
        |=> axil_rsp.rvalid) else $error("read answer missing");
    AST_WRITE_ANSWER: assert property (axil_req.awvalid && axil_rsp.awready
        && axil_req.wvalid && axil_rsp.wready |-> ##2 axil_rsp.bvalid)
        else $error("write answer missing");
    AST_B_HOLD: assert property (axil_rsp.bvalid && !axil_req.bready |=>
        axil_rsp.bvalid && $stable(axil_rsp.bresp)) else $error("write answer dropped");
    AST_R_HOLD: assert property (axil_rsp.rvalid && !axil_req.rready |=>
        axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("read answer dropped");
    AST_RDATA_BYTE: assert property (axil_rsp.rvalid
        |-> axil_rsp.rdata[31:8] == 24'h000000) else $error("read data wider than a byte");
    AST_AR_BLOCK: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
        else $error("read taken while answer pending");
    AST_AW_DROP: assert property (axil_req.awvalid && axil_rsp.awready
        |=> !axil_rsp.awready) else $error("write address ready stayed high");
    AST_W_DROP: assert property (axil_req.wvalid && axil_rsp.wready |=> !axil_rsp.wready)
        else $error("write data ready stayed high");
    // ----------------------------------------------------------------
    // Watchdog and coverage
    // ----------------------------------------------------------------
    AST_WDOG_PULSE: assert property ($rose(watchdog_reset_req) |=> !watchdog_reset_req)
        else $error("watchdog request longer than one cycle");
    cover property (watchdog_reset_req);
    cover property (module_irq);
    cover property (axil_rsp.rvalid && axil_rsp.rresp == RESP_SLVERR);
    cover property ($fell(module_io_pin_out[2]));
endmodule : pca_monitor

bind pca_compare_capture_watchdog pca_monitor i_pca_monitor (.clk_sys(clk_sys),
    .reset_n(reset_n), .axil_req(axil_req), .axil_rsp(axil_rsp),
    .module_io_pin_in(module_io_pin_in), .module_io_pin_out(module_io_pin_out),
    .module_io_pin_oe(module_io_pin_oe), .module_irq(module_irq),
    .watchdog_reset_req(watchdog_reset_req));

// [verif/pca_pin_model.sv]
// Outside world on the module pins: an external level, overridden where the block drives.
`timescale 1ns/1ps
module pca_pin_model (
    input wire logic [pca_pkg::NUM_MODULES-1:0] ext_level,
    input wire logic [pca_pkg::NUM_MODULES-1:0] pin_out,
    input wire logic [pca_pkg::NUM_MODULES-1:0] pin_oe,
    output logic [pca_pkg::NUM_MODULES-1:0] pin_in
);
    import pca_pkg::*;
    // A driven pin reads back its own level, so capture sees toggles too.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pca_pin_model

// [verif/tb_pca_compare_capture_watchdog.sv]
// Self-checking bench of the counter array.
`timescale 1ns/1ps
`define CHK(a, e) chk(32'(a), 32'(e))
module tb_pca_compare_capture_watchdog;
    import pca_pkg::*;
    localparam logic [IDX_W-1:0] MB = IDX_MODE_BASE;
    localparam logic [IDX_W-1:0] LB = IDX_CMP_LOW_BASE;
    localparam logic [IDX_W-1:0] HB = IDX_CMP_HIGH_BASE;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    axil_req_s req = '0;
    axil_rsp_s rsp;
    logic [NUM_MODULES-1:0] ext_level = '1;
    logic [NUM_MODULES-1:0] pin_in;
    logic [NUM_MODULES-1:0] pin_out;
    logic [NUM_MODULES-1:0] pin_oe;
    logic irq;
    logic wdog;
    logic [31:0] rdv;
    logic [1:0] resp;
    logic hit;
    int fail_count = 0;
    int n_tests = 0;
    always #5 clk_sys = ~clk_sys;
    pca_compare_capture_watchdog i_pca_compare_capture_watchdog (.clk_sys(clk_sys),
        .reset_n(reset_n), .axil_req(req), .axil_rsp(rsp), .module_io_pin_in(pin_in),
        .module_io_pin_out(pin_out), .module_io_pin_oe(pin_oe), .module_irq(irq),
        .watchdog_reset_req(wdog));
    pca_pin_model i_pca_pin_model (.ext_level(ext_level), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        req.awaddr <= {idx, 2'b00};
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) begin
                done = 1'b1;
                resp = rsp.bresp;
                req.bready <= 1'b0;
            end
        end
    endtask : wr
    task automatic rd(input logic [IDX_W-1:0] idx);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        req.araddr <= {idx, 2'b00};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) begin
                done = 1'b1;
                rdv = rsp.rdata;
                resp = rsp.rresp;
                req.rready <= 1'b0;
            end
        end
    endtask : rd
    task automatic rchk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
        rd(idx);
        `CHK(rdv, {24'h000000, exp});
    endtask : rchk
    // Bounded wait: 0 interrupt, 1 watchdog request, 2 or 3 pin 2 at level 0 or 1.
    task automatic wait_hit(input int which, input int lim);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge clk_sys);
            case (which)
                0: hit = (irq === 1'b1);
                1: hit = (wdog === 1'b1);
                default: hit = (pin_out[2] === which[0]);
            endcase
        end
    endtask : wait_hit
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rchk(IDX_COUNT_LOW, 8'h00);
        rchk(IDX_COUNT_HIGH, 8'h00);
        rchk(LB + 10'd4, 8'h00);
        rchk(HB, 8'h00);
        rd(10'h100);
        `CHK(resp, RESP_SLVERR);
        wr(IDX_COUNT_LOW, 8'h5A);
        rchk(IDX_COUNT_LOW, 8'h5A);
        wr(IDX_COUNT_HIGH, 8'hA5);
        rchk(IDX_COUNT_HIGH, 8'hA5);
    endtask : t_regs
    task automatic t_mode();
        for (int m = 0; m < NUM_MODULES; m++) begin
            wr(MB + 10'(m), 8'hFF);
            rchk(MB + 10'(m), 8'h7F);
            wr(LB + 10'(m), 8'h00);
            rchk(MB + 10'(m), 8'h3F);
            wr(HB + 10'(m), 8'h00);
            rchk(MB + 10'(m), 8'h7F);
            wr(MB + 10'(m), 8'h00);
            rchk(MB + 10'(m), 8'h00);
        end
    endtask : t_mode
    task automatic t_compare();
        wr(IDX_COUNT_LOW, 8'h00);
        wr(IDX_COUNT_HIGH, 8'h00);
        // Low byte first, non-zero values, as software must.
        for (int m = 1; m < 4; m++) begin
            wr(LB + 10'(m), (m == 1) ? 8'h40 : 8'h20);
            wr(HB + 10'(m), 8'h00);
        end
        wr(MB + 10'd1, 8'h49);
        wr(MB + 10'd2, 8'h4C);
        wr(MB + 10'd3, 8'h44);
        `CHK(pin_out[2], 1'b1);
        wr(IDX_FLAGS, 8'h40);
        wait_hit(2, 100);
        `CHK(hit, 1'b1);
        `CHK(pin_out[3], 1'b1);
        `CHK(pin_oe[3], 1'b0);
        `CHK(pin_oe[2], 1'b1);
        `CHK(irq, 1'b0);
        wait_hit(0, 100);
        `CHK(hit, 1'b1);
        wr(MB + 10'd1, 8'h48);
        `CHK(irq, 1'b0);
        rchk(IDX_FLAGS, 8'h46);
        wr(IDX_COUNT_LOW, 8'h00);
        wait_hit(3, 100);
        `CHK(hit, 1'b1);
        wr(IDX_FLAGS, 8'h00);
    endtask : t_compare
    task automatic t_capture();
        wr(MB, 8'h20);
        wr(IDX_COUNT_LOW, 8'h34);
        wr(IDX_COUNT_HIGH, 8'h12);
        ext_level[0] <= 1'b0;
        rchk(LB, 8'h00);
        ext_level[0] <= 1'b1;
        rchk(LB, 8'h34);
        rchk(HB, 8'h12);
        rchk(IDX_FLAGS, 8'h01);
        wr(MB, 8'h10);
        wr(IDX_COUNT_LOW, 8'h56);
        ext_level[0] <= 1'b0;
        rchk(LB, 8'h56);
        wr(MB, 8'h00);
    endtask : t_capture
    task automatic t_pwm();
        wr(HB + 10'd1, 8'h80);
        wr(MB + 10'd1, 8'h42);
        wr(IDX_COUNT_LOW, 8'h7F);
        repeat (2) @(posedge clk_sys);
        `CHK(pin_out[1], 1'b1);
        `CHK(pin_oe[1], 1'b1);
        // Long enough for the low byte to wrap and load the new duty.
        wr(IDX_FLAGS, 8'h40);
        repeat (300) @(posedge clk_sys);
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_COUNT_LOW, 8'h7F);
        repeat (2) @(posedge clk_sys);
        `CHK(pin_out[1], 1'b0);
        wr(IDX_COUNT_LOW, 8'h80);
        repeat (2) @(posedge clk_sys);
        `CHK(pin_out[1], 1'b1);
    endtask : t_pwm
    task automatic t_wdog();
        wr(LB + 10'd4, 8'h30);
        wr(HB + 10'd4, 8'h00);
        wr(MB + 10'd4, 8'h48);
        wr(IDX_WDOG_CTRL, 8'h01);
        wr(IDX_COUNT_LOW, 8'h00);
        wr(IDX_COUNT_HIGH, 8'h00);
        wr(IDX_FLAGS, 8'h40);
        wait_hit(1, 40);
        `CHK(hit, 1'b0);
        wait_hit(1, 100);
        `CHK(hit, 1'b1);
        rchk(IDX_WDOG_CTRL, 8'h03);
        wr(IDX_WDOG_CTRL, 8'h00);
        wr(IDX_COUNT_LOW, 8'h00);
        wait_hit(1, 100);
        `CHK(hit, 1'b0);
        wr(IDX_FLAGS, 8'h00);
    endtask : t_wdog
    task automatic final_report();
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_regs();
        t_mode();
        t_compare();
        t_capture();
        t_pwm();
        t_wdog();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        final_report();
    end
endmodule : tb_pca_compare_capture_watchdog
